// *** rtc_pkg.sv ***
// Package: offsets, field positions, reset values and timing for the RTC support block
package rtc_pkg;

  // ************************************************************
  // Clock and time figures
  // ************************************************************
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned OSC_FAIL_MS     = 5;
  localparam int unsigned OSC_START_MAX_S = 2;
  localparam int unsigned OSC_FAIL_CYC    = CLK_HZ / 1000 * OSC_FAIL_MS;
  localparam int unsigned OSC_START_CYC   = CLK_HZ * OSC_START_MAX_S;

  // ************************************************************
  // Oscillator divider figures
  // ************************************************************
  localparam logic [15:0] SEC_CYC      = 16'h8000;
  localparam logic [15:0] CAL_SHORTEN  = 16'h0080;
  localparam logic [15:0] CAL_LENGTHEN = 16'h0100;
  localparam logic [5:0]  CAL_LAST_MIN = 6'h3e;
  localparam logic [5:0]  SEC_LAST     = 6'h3b;
  localparam logic [9:0]  DOG_DIV_LAST = 10'h3ff;
  localparam int          SQW_1HZ_BIT  = 14;
  localparam int          SQW_512_BIT  = 5;
  localparam int          SQW_4K_BIT   = 2;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [3:0] ADDR_FLAGS    = 4'h0;
  localparam logic [3:0] ADDR_ALM_SEC  = 4'h2;
  localparam logic [3:0] ADDR_ALM_DATE = 4'h5;
  localparam logic [3:0] ADDR_IRQ      = 4'h6;
  localparam logic [3:0] ADDR_DOG      = 4'h7;
  localparam logic [3:0] ADDR_TRIM     = 4'h8;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int FLG_WRITE    = 1;
  localparam int FLG_CAL      = 2;
  localparam int FLG_OSC_FAIL_FLAG     = 4;
  localparam int FLG_AF       = 6;
  localparam int FLG_WDF      = 7;
  localparam int IRQ_WIE      = 7;
  localparam int IRQ_AIE      = 6;
  localparam int IRQ_SQWE     = 4;
  localparam int IRQ_SQ_HI    = 1;
  localparam int IRQ_SQ_LO    = 0;
  localparam int DOG_STROBE   = 7;
  localparam int DOG_LOCK     = 6;
  localparam int TRIM_OSC_DIS = 7;
  localparam int TRIM_SIGN    = 5;
  localparam int ALM_MATCH    = 7;

  // ************************************************************
  // Values after reset
  // ************************************************************
  localparam logic [7:0] TRIM_RST = 8'h00;
  localparam logic [7:0] IRQ_RST  = 8'h00;
  localparam logic [7:0] DOG_RST  = 8'h00;
  localparam logic [7:0] ALM_RST  = 8'h00;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    CHK_IDLE  = 2'b00,
    CHK_WATCH = 2'b01,
    CHK_OK    = 2'b10,
    CHK_FAIL  = 2'b11
  } osc_chk_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] date;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } cur_time_t;

endpackage

// *** sync2.sv ***
// Two-flop synchroniser for levels entering the clk domain
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // sync2

// *** rtc_support.sv ***
// RTC support: oscillator check, calibration, alarm, watchdog, square wave, backup
// How it works
// - Trim bit 7 set stops the oscillator; cleared (shipping state) runs it.
// - After re-enable the oscillator must start within two seconds.
// - On power-up, enabled oscillator silent for 5 ms sets the fail flag.
// - On failure time reloads base time; control and trim stay untouched.
// - Trim holds magnitude 0..31 in bits 4:0, sign in bit 5.
// - 64-minute cycle; one second shortened 128 or lengthened 256 cycles.
// - Magnitude N modifies first 2N minutes, once each, at most 62.
// - Calibration test bit drives uncalibrated 512 Hz on interrupt pin.
// - Alarm match sets alarm flag; pin driven only with alarm enable.
// - Each alarm field's match bit: 0 compares it, 1 ignores it.
// - Reading flags clears alarm, watchdog flags and releases the pin.
// - Alarm writes take effect when write-unlock returns to zero.
// - Watchdog counts down on 32 Hz tick, only with oscillator running.
// - Watchdog loads at power-up and reloads on every strobe write.
// - Watchdog reaching zero sets its flag; pin driven with its enable.
// - Watchdog timeout field writable only while its lock bit is zero.
// - Timeout value zero disables the watchdog completely.
// - Square wave 1, 512, 4096, 32768 Hz; silent on backup power.
// - On backup power register access blocked, timekeeping keeps running.
// - Write-unlock freezes time; clearing it commits values to counters.
// - Frequency select 00 1 Hz, 01 512, 10 4096, 11 32768 Hz.
module rtc_support
  import rtc_pkg::*;
#(
  parameter int unsigned FAIL_WIN  = rtc_pkg::OSC_FAIL_CYC,
  parameter int unsigned START_WIN = rtc_pkg::OSC_START_CYC
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              osc_in,
  input  wire logic              vcc_ok,
  input  wire rtc_pkg::reg_req_t reg_req,
  input  wire rtc_pkg::cur_time_t cur_time,
  output logic [7:0]             reg_rdata,
  output logic                   osc_enable,
  output logic                   sec_tick,
  output logic                   time_frozen,
  output logic                   time_commit,
  output logic                   time_reload,
  output logic                   int_out,
  output logic                   int_oe
);
  import rtc_pkg::*;

  // ************************************************************
  // Pin synchronisation and edges
  // ************************************************************
  logic [1:0]  pins_s;
  logic        osc_q_r;
  logic        vcc_q_r;
  logic        osc_rise;
  logic        vcc_rise;
  logic        backup;

  sync2 #(.W(2)) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({vcc_ok, osc_in}),
    .q      (pins_s)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_q_r <= 1'b0;
      vcc_q_r <= 1'b0;
    end else begin
      osc_q_r <= pins_s[0];
      vcc_q_r <= pins_s[1];
    end
  end

  assign osc_rise = pins_s[0] & ~osc_q_r;
  assign vcc_rise = pins_s[1] & ~vcc_q_r;
  assign backup   = ~pins_s[1];

  // ************************************************************
  // Register access decode
  // ************************************************************
  logic       wr_ok;
  logic       rd_ok;
  logic       flags_rd;
  logic       unlock_r;
  logic       cal_test_r;
  logic       osc_fail_flag_r;
  logic       alarm_match_flag_r;
  logic       dog_timeout_flag_r;
  logic [7:0] irq_r;
  logic [7:0] trim_r;
  logic [5:0] dog_value_r;
  logic       dog_value_lock_r;
  logic       dog_strobe;
  logic [5:0] dog_value_nxt;
  logic [7:0] alm_stage_r [0:3];
  logic [7:0] alm_live_r  [0:3];
  logic [1:0] alm_idx;
  logic       alm_addr;
  logic       unlock_fall;

  // Backup blocks access
  // access blocked
  assign wr_ok    = reg_req.wr & ~backup;
  assign rd_ok    = reg_req.rd & ~backup;
  assign flags_rd = rd_ok && (reg_req.addr == ADDR_FLAGS);
  assign alm_addr = (reg_req.addr >= ADDR_ALM_SEC) && (reg_req.addr <= ADDR_ALM_DATE);
  assign alm_idx  = 2'(reg_req.addr - ADDR_ALM_SEC);
  assign dog_strobe = wr_ok && (reg_req.addr == ADDR_DOG) && reg_req.wdata[DOG_STROBE];
  assign unlock_fall = wr_ok && (reg_req.addr == ADDR_FLAGS) && unlock_r && !reg_req.wdata[FLG_WRITE];

  // Write-unlock and calibration test bit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      unlock_r   <= 1'b0;
      cal_test_r <= 1'b0;
    end else if (wr_ok && reg_req.addr == ADDR_FLAGS) begin
      unlock_r <= reg_req.wdata[FLG_WRITE];
      if (unlock_r) begin
        cal_test_r <= reg_req.wdata[FLG_CAL];
      end
    end
  end

  // Interrupt control and trim registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_r  <= IRQ_RST;
      trim_r <= TRIM_RST;
    end else if (wr_ok && reg_req.addr == ADDR_IRQ) begin
      irq_r <= reg_req.wdata;
    end else if (wr_ok && reg_req.addr == ADDR_TRIM) begin
      trim_r <= {reg_req.wdata[7], 1'b0, reg_req.wdata[5:0]};
    end
  end

  always_comb begin
    dog_value_nxt = dog_value_r;
    if (wr_ok && reg_req.addr == ADDR_DOG && !dog_value_lock_r && !reg_req.wdata[DOG_LOCK]) begin
      dog_value_nxt = reg_req.wdata[5:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dog_value_r      <= DOG_RST[5:0];
      dog_value_lock_r <= DOG_RST[DOG_LOCK];
    end else begin
      dog_value_r <= dog_value_nxt;
      if (wr_ok && reg_req.addr == ADDR_DOG) begin
        dog_value_lock_r <= reg_req.wdata[DOG_LOCK];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        alm_stage_r[i] <= ALM_RST;
        alm_live_r[i]  <= ALM_RST;
      end
    end else begin
      if (wr_ok && alm_addr && unlock_r) begin
        alm_stage_r[alm_idx] <= reg_req.wdata;
      end
      if (unlock_fall) begin
        for (int i = 0; i < 4; i++) begin
          alm_live_r[i] <= alm_stage_r[i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      time_frozen <= 1'b0;
      time_commit <= 1'b0;
    end else begin
      time_frozen <= unlock_r;
      time_commit <= unlock_fall;
    end
  end

  // Read data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (rd_ok) begin
      if (reg_req.addr == ADDR_FLAGS) begin
        reg_rdata <= {dog_timeout_flag_r, alarm_match_flag_r, 1'b0, osc_fail_flag_r,
                      1'b0, cal_test_r, unlock_r, 1'b0};
      end else if (alm_addr) begin
        reg_rdata <= alm_stage_r[alm_idx];
      end else if (reg_req.addr == ADDR_IRQ) begin
        reg_rdata <= irq_r;
      end else if (reg_req.addr == ADDR_DOG) begin
        reg_rdata <= {1'b0, dog_value_lock_r, dog_value_r};
      end else if (reg_req.addr == ADDR_TRIM) begin
        reg_rdata <= trim_r;
      end else begin
        reg_rdata <= 8'h00;
      end
    end else if (reg_req.rd) begin
      reg_rdata <= 8'h00;
    end
  end

  // ************************************************************
  // Oscillator enable and failure check
  // ************************************************************
  osc_chk_t   chk_r;
  logic [31:0] win_cnt_r;
  logic [31:0] win_lim_r;
  logic        osc_dis_q_r;
  logic        osc_fail_set;
  logic        osc_running;

  assign osc_running  = (chk_r == CHK_OK);
  assign osc_fail_set = (chk_r == CHK_WATCH) && (win_cnt_r >= win_lim_r) && !osc_rise;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_enable  <= 1'b0;
      osc_dis_q_r <= 1'b1;
    end else begin
      osc_enable  <= ~trim_r[TRIM_OSC_DIS];
      osc_dis_q_r <= trim_r[TRIM_OSC_DIS];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chk_r     <= CHK_IDLE;
      win_cnt_r <= 32'h0;
      win_lim_r <= 32'h0;
    end else if (trim_r[TRIM_OSC_DIS]) begin
      chk_r <= CHK_IDLE;
    end else if (vcc_rise) begin
      chk_r     <= CHK_WATCH;
      win_cnt_r <= 32'h0;
      win_lim_r <= 32'(FAIL_WIN);
    end else if (osc_dis_q_r) begin
      chk_r     <= CHK_WATCH;
      win_cnt_r <= 32'h0;
      win_lim_r <= 32'(START_WIN);
    end else begin
      case (chk_r)
        CHK_IDLE: begin
          chk_r <= CHK_WATCH;
          win_cnt_r <= 32'h0;
          win_lim_r <= 32'(START_WIN);
        end
        CHK_WATCH: begin
          win_cnt_r <= win_cnt_r + 32'h1;
          if (osc_rise) begin
            chk_r <= CHK_OK;
          end else if (osc_fail_set) begin
            chk_r <= CHK_FAIL;
          end
        end
        CHK_FAIL: begin
          if (osc_rise) begin
            chk_r <= CHK_OK;
          end
        end
        default: begin
          chk_r <= CHK_OK;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      time_reload <= 1'b0;
    end else begin
      time_reload <= osc_fail_set;
    end
  end

  // ************************************************************
  // Flags: set wins over clear
  // ************************************************************
  logic alarm_set;
  logic dog_expire;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_fail_flag_r    <= 1'b0;
      alarm_match_flag_r <= 1'b0;
      dog_timeout_flag_r <= 1'b0;
    end else begin
      if (osc_fail_set) begin
        osc_fail_flag_r <= 1'b1;
      end else if (wr_ok && reg_req.addr == ADDR_FLAGS && unlock_r && !reg_req.wdata[FLG_OSC_FAIL_FLAG]) begin
        osc_fail_flag_r <= 1'b0;
      end
      if (alarm_set) begin
        alarm_match_flag_r <= 1'b1;
      end else if (flags_rd) begin
        alarm_match_flag_r <= 1'b0;
      end
      if (dog_expire) begin
        dog_timeout_flag_r <= 1'b1;
      end else if (flags_rd) begin
        dog_timeout_flag_r <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Divider chain with calibration
  // ************************************************************
  logic [14:0] osc_cnt_r;
  logic [15:0] div_cnt_r;
  logic [5:0]  sec_idx_r;
  logic [5:0]  min_idx_r;
  logic        cal_mod;
  logic [15:0] sec_last;
  logic        tick32;

  assign cal_mod = (sec_idx_r == 6'h00) && (min_idx_r < {trim_r[4:0], 1'b0})
                   && (min_idx_r < CAL_LAST_MIN);
  assign sec_last = !cal_mod ? SEC_CYC - 16'h1 :
                    trim_r[TRIM_SIGN] ? SEC_CYC + CAL_LENGTHEN - 16'h1 :
                    SEC_CYC - CAL_SHORTEN - 16'h1;
  assign tick32 = osc_rise && (osc_cnt_r[9:0] == DOG_DIV_LAST);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_cnt_r <= 15'h0;
      div_cnt_r <= 16'h0;
      sec_idx_r <= 6'h0;
      min_idx_r <= 6'h0;
      sec_tick  <= 1'b0;
    end else begin
      sec_tick <= 1'b0;
      if (osc_rise) begin
        osc_cnt_r <= osc_cnt_r + 15'h1;
        if (div_cnt_r >= sec_last) begin
          div_cnt_r <= 16'h0;
          sec_tick  <= 1'b1;
          if (sec_idx_r == SEC_LAST) begin
            sec_idx_r <= 6'h0;
            min_idx_r <= min_idx_r + 6'h1;
          end else begin
            sec_idx_r <= sec_idx_r + 6'h1;
          end
        end else begin
          div_cnt_r <= div_cnt_r + 16'h1;
        end
      end
    end
  end

  // ************************************************************
  // Alarm compare
  // ************************************************************
  logic [7:0] cur_f [0:3];
  logic [3:0] fld_ok;
  logic       match_q_r;

  assign cur_f[0] = cur_time.sec;
  assign cur_f[1] = cur_time.min;
  assign cur_f[2] = cur_time.hour;
  assign cur_f[3] = cur_time.date;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      fld_ok[i] = alm_live_r[i][ALM_MATCH] || (alm_live_r[i][6:0] == cur_f[i][6:0]);
    end
  end

  assign alarm_set = (&fld_ok) && !match_q_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      match_q_r <= 1'b1;
    end else begin
      match_q_r <= &fld_ok;
    end
  end

  // ************************************************************
  // Watchdog
  // ************************************************************
  logic [5:0] dog_cnt_r;

  assign dog_expire = tick32 && osc_running && (dog_value_r != 6'h0) && (dog_cnt_r == 6'h1)
                      && !dog_strobe && !vcc_rise;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dog_cnt_r <= DOG_RST[5:0];
    end else if (vcc_rise || dog_strobe) begin
      dog_cnt_r <= dog_value_nxt;
    end else if (tick32 && osc_running && dog_value_r != 6'h0 && dog_cnt_r != 6'h0) begin
      dog_cnt_r <= dog_cnt_r - 6'h1;
    end
  end

  // ************************************************************
  // Interrupt pin
  // ************************************************************
  logic sqw_level;
  logic irq_pend;

  always_comb begin
    case ({irq_r[IRQ_SQ_HI], irq_r[IRQ_SQ_LO]})
      2'b00:   sqw_level = osc_cnt_r[SQW_1HZ_BIT];
      2'b01:   sqw_level = osc_cnt_r[SQW_512_BIT];
      2'b10:   sqw_level = osc_cnt_r[SQW_4K_BIT];
      default: sqw_level = pins_s[0];
    endcase
  end

  assign irq_pend = (dog_timeout_flag_r && irq_r[IRQ_WIE]) || (alarm_match_flag_r && irq_r[IRQ_AIE]);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_out <= 1'b0;
      int_oe  <= 1'b0;
    end else if (backup) begin
      int_out <= 1'b0;
      int_oe  <= 1'b0;
    end else if (cal_test_r) begin
      int_out <= osc_cnt_r[SQW_512_BIT];
      int_oe  <= 1'b1;
    end else if (irq_r[IRQ_SQWE]) begin
      int_out <= sqw_level;
      int_oe  <= 1'b1;
    end else begin
      int_out <= irq_pend;
      int_oe  <= irq_pend;
    end
  end
endmodule // rtc_support

// *** rtc_support_asserts.sv ***
// Checker: port-level properties of the RTC support block
module rtc_support_asserts
  import rtc_pkg::*;
(
  input wire logic                clk,
  input wire logic                arst_n,
  input wire logic                osc_in,
  input wire logic                vcc_ok,
  input wire rtc_pkg::reg_req_t   reg_req,
  input wire rtc_pkg::cur_time_t  cur_time,
  input wire logic [7:0]          reg_rdata,
  input wire logic                osc_enable,
  input wire logic                sec_tick,
  input wire logic                time_frozen,
  input wire logic                time_commit,
  input wire logic                time_reload,
  input wire logic                int_out,
  input wire logic                int_oe
);
  logic last_dis_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // ****************
  // Helper and sequences
  // ****************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last_dis_r <= 1'b0;
    end else if (reg_req.wr && reg_req.addr == ADDR_TRIM && vcc_ok) begin
      last_dis_r <= reg_req.wdata[TRIM_OSC_DIS];
    end
  end

  sequence s_vcc_up;
    vcc_ok [*4];
  endsequence

  sequence s_backup;
    !vcc_ok [*4];
  endsequence

  // ****************
  // Properties
  // ****************
  AST_OSC_EN: assert property (
    s_vcc_up ##0 (reg_req.wr && reg_req.addr == ADDR_TRIM) |-> ##2 osc_enable == !last_dis_r)
    else $error("osc_enable does not follow the disable bit");
  AST_FROZEN_SET: assert property (
    s_vcc_up ##0 (reg_req.wr && reg_req.addr == ADDR_FLAGS && reg_req.wdata[FLG_WRITE]) |-> ##2 time_frozen)
    else $error("time_frozen not raised by unlock");
  AST_COMMIT: assert property (
    time_commit |-> $past(time_frozen) ##1 !time_frozen)
    else $error("commit without a preceding freeze");
  AST_COMMIT_PULSE: assert property (
    time_commit |=> !time_commit)
    else $error("time_commit longer than one cycle");
  AST_BACKUP_OE: assert property (
    s_backup |-> !int_oe)
    else $error("interrupt pin driven on backup power");
  AST_BACKUP_RD: assert property (
    s_backup ##0 reg_req.rd |-> ##2 reg_rdata == 8'h00)
    else $error("register read visible on backup power");
  AST_TRIM_RD: assert property (
    (reg_req.rd && reg_req.addr == ADDR_TRIM) |-> ##2 !reg_rdata[6])
    else $error("trim bit 6 reads as one");
  AST_RELOAD_PULSE: assert property (
    time_reload |=> !time_reload)
    else $error("time_reload longer than one cycle");
endmodule // rtc_support_asserts

bind rtc_support rtc_support_asserts u_chk (
  .clk(clk), .arst_n(arst_n), .osc_in(osc_in), .vcc_ok(vcc_ok), .reg_req(reg_req),
  .cur_time(cur_time), .reg_rdata(reg_rdata), .osc_enable(osc_enable), .sec_tick(sec_tick),
  .time_frozen(time_frozen), .time_commit(time_commit), .time_reload(time_reload),
  .int_out(int_out), .int_oe(int_oe)
);

// *** rtc_xtal_model.sv ***
// Crystal model: scaled-up stand-in for the 32 kHz oscillator, still when stopped
module rtc_xtal_model #(
  parameter int HALF_NS = 16
) (
  input  wire logic run,
  output logic      osc
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    osc = 1'b0;
    #3;
    forever begin
      #(HALF_NS);
      osc = run ? !osc : 1'b0;
    end
  end
endmodule // rtc_xtal_model

// *** rtc_support_test.sv ***
// Testbench: self-checking run of the RTC support block
module rtc_support_test;
  timeunit 1ns;
  timeprecision 100ps;
  import rtc_pkg::*;
  localparam int unsigned FW = 200;
  localparam logic [7:0] DOGW [4] = '{8'h01, 8'h45, 8'h3f, 8'h81};
  localparam logic [7:0] ALMV [4] = '{8'h45, 8'h30, 8'h12, 8'h95};
  localparam logic [31:0] TV [2] = '{32'h2012_3045, 32'h2013_3045};
  localparam logic [7:0] TE [2] = '{8'h40, 8'h00};
  logic       clk, arst_n, osc_in, vcc_ok, run;
  reg_req_t   req;
  cur_time_t  tnow;
  logic [7:0] rdata, d, v;
  logic       osc_enable, sec_tick, time_frozen, time_commit, time_reload, int_out, int_oe;
  int         mismatches = 0;
  int         n_checks = 0;
  int         seed = 98;
  int         n_commit = 0;
  int         n_reload = 0;
  int         n_sec = 0;
  int         k, n;

  rtc_support #(.FAIL_WIN(FW), .START_WIN(500)) uut (
    .clk(clk), .arst_n(arst_n), .osc_in(osc_in), .vcc_ok(vcc_ok), .reg_req(req), .cur_time(tnow),
    .reg_rdata(rdata), .osc_enable(osc_enable), .sec_tick(sec_tick), .time_frozen(time_frozen),
    .time_commit(time_commit), .time_reload(time_reload), .int_out(int_out), .int_oe(int_oe));
  rtc_xtal_model #(.HALF_NS(16)) xtal (.run(run && osc_enable === 1'b1), .osc(osc_in));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (time_commit === 1'b1) n_commit++;
    if (time_reload === 1'b1) n_reload++;
    if (sec_tick === 1'b1) n_sec++;
  end

  // ****************
  // Tasks and expectations
  // ****************
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] dt);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: dt};
    @(negedge clk);
    req = '0;
    @(negedge clk);
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req = '0;
    @(negedge clk);
    chk(nm, rdata & m, exp);
  endtask
  task automatic tog(input int cyc, output int cnt);
    logic p;
    cnt = 0;
    p = int_out;
    repeat (cyc) begin
      @(negedge clk);
      if (int_out !== p) cnt++;
      p = int_out;
    end
  endtask
  function automatic logic [7:0] band(input int got, input int exp);
    return (got >= exp - 1 && got <= exp + 1) ? 8'h01 : 8'h00;
  endfunction
  function automatic logic [7:0] dog_exp(input logic [7:0] old, input logic [7:0] x);
    logic lk;
    lk = old[DOG_LOCK] | x[DOG_LOCK];
    return {1'b0, x[DOG_LOCK], lk ? old[5:0] : x[5:0]};
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  initial begin
    arst_n = 1'b0;
    vcc_ok = 1'b1;
    run = 1'b1;
    req = '0;
    tnow = 32'h1512_3045;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    for (k = 0; k < 10; k++) rchk("reset value", k[3:0], 8'hff, 8'h00);
    chk("osc run", {7'h0, osc_enable}, 8'h01);
    for (k = 0; k < 8; k++) begin
      d = 8'($random(seed));
      wr(ADDR_IRQ, d);
      rchk("irq reg", ADDR_IRQ, 8'hff, d);
    end
    wr(ADDR_IRQ, 8'h00);
    for (k = 0; k < 6; k++) begin
      d = (k == 5) ? 8'h25 : (8'($random(seed)) & 8'h7f);
      wr(ADDR_TRIM, d);
      rchk("trim", ADDR_TRIM, 8'hff, d & 8'hbf);
    end
    wr(ADDR_TRIM, 8'ha5);
    chk("osc off", {7'h0, osc_enable}, 8'h00);
    wr(ADDR_TRIM, 8'h25);
    chk("osc on", {7'h0, osc_enable}, 8'h01);
    $display("test registers finished");
    wr(ADDR_IRQ, 8'h80);
    v = 8'h00;
    for (k = 0; k < 4; k++) begin
      v = dog_exp(v, DOGW[k]);
      wr(ADDR_DOG, DOGW[k]);
      rchk("dog reg", ADDR_DOG, 8'hff, v);
    end
    for (n = 0; int_oe !== 1'b1 && n < 10000; n++) @(negedge clk);
    chk("dog span", {7'h0, n < 4200}, 8'h01);
    chk("dog pin", {7'h0, int_out}, 8'h01);
    rchk("dog flag", ADDR_FLAGS, 8'h80, 8'h80);
    chk("dog pin clr", {7'h0, int_oe}, 8'h00);
    wr(ADDR_DOG, 8'h80);
    tog(9000, n);
    chk("dog off", {7'h0, n == 0 && int_oe === 1'b0}, 8'h01);
    wr(ADDR_IRQ, 8'h00);
    $display("test watchdog finished");
    wr(ADDR_ALM_SEC, 8'h11);
    rchk("alarm locked", ADDR_ALM_SEC, 8'hff, 8'h00);
    n = n_commit;
    wr(ADDR_FLAGS, 8'h02);
    for (k = 0; k < 4; k++) wr(ADDR_ALM_SEC + k[3:0], ALMV[k]);
    wr(ADDR_IRQ, 8'h40);
    wr(ADDR_FLAGS, 8'h00);
    repeat (3) @(negedge clk);
    chk("commit", {7'h0, n_commit == n + 1}, 8'h01);
    chk("alarm pin", {6'h0, int_oe, int_out}, 8'h03);
    rchk("alarm flag", ADDR_FLAGS, 8'hc0, 8'h40);
    chk("alarm pin clr", {7'h0, int_oe}, 8'h00);
    rchk("flag cleared", ADDR_FLAGS, 8'hc0, 8'h00);
    for (k = 0; k < 2; k++) begin
      tnow = TV[k] - 32'h1;
      repeat (3) @(negedge clk);
      tnow = TV[k];
      repeat (4) @(negedge clk);
      rchk("alarm mask", ADDR_FLAGS, 8'hc0, TE[k]);
    end
    wr(ADDR_IRQ, 8'h00);
    $display("test alarm finished");
    wr(ADDR_FLAGS, 8'h04);
    rchk("cal locked", ADDR_FLAGS, 8'h04, 8'h00);
    wr(ADDR_FLAGS, 8'h02);
    wr(ADDR_FLAGS, 8'h06);
    wr(ADDR_FLAGS, 8'h04);
    rchk("cal set", ADDR_FLAGS, 8'h06, 8'h04);
    tog(256, n);
    chk("cal 512", band(n, 2), 8'h01);
    wr(ADDR_FLAGS, 8'h02);
    wr(ADDR_FLAGS, 8'h00);
    for (k = 1; k < 4; k++) begin
      wr(ADDR_IRQ, 8'h10 | k[7:0]);
      tog(256, n);
      chk("sqw rate", band(n, 128 >> (3 * (3 - k))), 8'h01);
    end
    chk("sqw oe", {7'h0, int_oe}, 8'h01);
    $display("test square wave finished");
    vcc_ok = 1'b0;
    repeat (5) @(negedge clk);
    chk("sqw backup", {7'h0, int_oe}, 8'h00);
    wr(ADDR_TRIM, 8'h00);
    rchk("trim backup", ADDR_TRIM, 8'hff, 8'h00);
    run = 1'b0;
    n = n_reload;
    vcc_ok = 1'b1;
    repeat (FW + 20) @(negedge clk);
    chk("reload", {7'h0, n_reload == n + 1}, 8'h01);
    rchk("trim after", ADDR_TRIM, 8'hff, 8'h25);
    rchk("irq kept", ADDR_IRQ, 8'hff, 8'h13);
    rchk("osc fail", ADDR_FLAGS, 8'hff, 8'h10);
    wr(ADDR_FLAGS, 8'h02);
    wr(ADDR_FLAGS, 8'h02);
    wr(ADDR_FLAGS, 8'h00);
    rchk("osc fail clr", ADDR_FLAGS, 8'hff, 8'h00);
    chk("no early second", {7'h0, n_sec == 0}, 8'h01);
    $display("test backup finished");
    stop_test();
  end

  initial begin
    #(60000 * 8);
    mismatches++;
    stop_test();
  end
endmodule // rtc_support_test
